/* hdl/jfp_pkg.sv */
// Purpose: Shared constants for the scan-port page programming logic
// Assumes: 4-bit instruction register, 128-word flash page of 16-bit words
// Notes:   Instruction codes are local choices of this design
package jfp_pkg;
	localparam int unsigned IR_W         = 4;
	localparam int unsigned KEY_W        = 16;
	localparam int unsigned CMD_W        = 15;
	localparam int unsigned BYTE_W       = 8;
	localparam int unsigned PAGE_WORDS   = 128;
	localparam int unsigned PAGE_BYTES   = PAGE_WORDS * 2;
	localparam int unsigned PAGE_AW      = $clog2(PAGE_BYTES);
	localparam int unsigned ADDR_W       = 16;
	// Highest implemented address bits; higher ones are don't care
	localparam int unsigned flash_addr_top_bit  = 15;
	localparam int unsigned eeprom_addr_top_bit = 11;
	localparam int unsigned PAGE_WORD_BITS      = $clog2(PAGE_WORDS);

	// Instruction codes
	localparam logic [IR_W-1:0] scan_reset_instr     = 4'hc;
	localparam logic [IR_W-1:0] program_unlock_instr = 4'h4;
	localparam logic [IR_W-1:0] program_cmd_instr    = 4'h5;
	localparam logic [IR_W-1:0] page_fill_instr      = 4'h6;
	localparam logic [IR_W-1:0] page_dump_instr      = 4'h7;

	localparam logic [KEY_W-1:0] UNLOCK_KEY   = 16'ha370;
	localparam logic [CMD_W-1:0] CMD_NOP_A    = 15'h2300;
	localparam logic [CMD_W-1:0] CMD_NOP_B    = 15'h3300;
	// Upper seven command bits select address loads
	localparam logic [6:0]       CMD_ADDR_HI  = 7'h07;
	localparam logic [6:0]       CMD_ADDR_LO  = 7'h03;
	localparam int unsigned      CMD_OP_LSB   = 8;

	localparam logic [2:0]        BIT_LAST    = 3'h7;
	localparam logic [ADDR_W-1:0] ADDR_RST    = 16'h0000;
endpackage

/* hdl/jfp_page_mem.sv */
// Purpose: Page buffer memory, one write port and one registered read port
// Assumes: Both ports on the same clock
// Notes:   Read data appear one edge after the address is presented
`timescale 1ns/1ps
`default_nettype none
module jfp_page_mem #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 256,
	parameter int unsigned AW    = 8
) (
	input  wire logic             clk,     // Memory clock
	input  wire logic             wrEn,    // Write strobe
	input  wire logic [AW-1:0]    wrAddr,  // Write address
	input  wire logic [WIDTH-1:0] wrData,  // Write data
	input  wire logic [AW-1:0]    rdAddr,  // Read address
	output logic      [WIDTH-1:0] rdData   // Registered read data
);
	logic [WIDTH-1:0] store [DEPTH];

	// Array write and registered read; no reset so it maps onto RAM
	always_ff @(posedge clk) begin
		if (wrEn) begin
			store[wrAddr] <= wrData;
		end
		rdData <= store[rdAddr];
	end
endmodule // jfp_page_mem
`default_nettype wire

/* hdl/jfp_prog_port.sv */
// Purpose: Programming-mode entry/exit and page fill/dump scan chains
// Assumes: External tap decodes instructions and drives capture/shift/update
// Notes:   Chain logic runs on tck; core side sees synchronised results
// Function
// RULE1 - The fill chain looks one page long but moves each finished byte into the page buffer.
// RULE2 - The programmer shifts the page from bit zero of the first word to the top bit of the last.
// RULE3 - The whole page buffer is filled before the page write command is given.
// RULE4 - The dump chain looks one page plus eight bits long, reloading its byte register from the page.
// RULE5 - The first eight dump shifts load the first byte and their output is discarded.
// RULE6 - After those eight shifts page data leave from bit zero of the first word onward.
// RULE7 - Address bits above the implemented flash or eeprom top bit are ignored.
// RULE8 - Entry starts by shifting a one into the reset register to hold the device in reset.
// RULE9 - Programming mode is entered only on the exact 16-bit unlock key.
// RULE10 - Exit starts by issuing the no-operation command in command mode.
// RULE11 - Shifting all zeros into the unlock register drops programming mode.
// RULE12 - Exit ends by shifting a zero into the reset register, releasing reset.
// RULE13 - The no-operation command is the two 15-bit shifts 0100011_00000000 then 0110011_00000000.
// RULE14 - Fill, dump and command instructions act only while the key is held and reset is asserted.
// RULE15 - Fill and dump start at the page base and step the byte address every eight shifts.
`timescale 1ns/1ps
`default_nettype none
module jfp_prog_port (
	input  wire logic                        clk,            // Core clock
	input  wire logic                        reset,          // Core sync reset
	input  wire logic                        tck,            // Scan clock
	input  wire logic                        tapReset,       // Tap reset, tck
	input  wire logic [jfp_pkg::IR_W-1:0]    instr,          // Active instr
	input  wire logic                        captureDr,      // Capture state
	input  wire logic                        shiftDr,        // Shift state
	input  wire logic                        updateDr,       // Update state
	input  wire logic                        tdi,            // Scan data in
	output logic                             tdo,            // Scan data out
	output logic                             holdReset,      // Core held
	output logic                             progMode,       // Mode active
	output logic                             pageFilled,     // Fill done pulse
	output logic [jfp_pkg::ADDR_W-1:0]       flashWordAddr,  // Page base
	output logic [jfp_pkg::ADDR_W-1:0]       eepromAddr      // Eeprom address
);
	localparam int unsigned AW = jfp_pkg::PAGE_AW;
	localparam int unsigned AWD = jfp_pkg::ADDR_W;

	// Instruction gate shared by every chain
	function automatic logic isInstr(input logic [jfp_pkg::IR_W-1:0] code,
			input logic [jfp_pkg::IR_W-1:0] want);
		return code == want;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Scan clock domain
	logic                       resetHold_ff, nxt_resetHold;
	logic [jfp_pkg::KEY_W-1:0]  keySr_ff, nxt_keySr;
	logic                       keyOk_ff, nxt_keyOk;
	logic [jfp_pkg::CMD_W-1:0]  cmdSr_ff, nxt_cmdSr;
	logic [AWD-1:0]             addr_ff, nxt_addr;
	logic [2:0]                 bitCnt_ff, nxt_bitCnt;
	logic [AW-1:0]              byteAddr_ff, nxt_byteAddr;
	logic [jfp_pkg::BYTE_W-1:0] byteSr_ff, nxt_byteSr;
	logic                       tdo_ff, nxt_tdo;
	logic                       fillTgl_ff, nxt_fillTgl;
	logic [AWD-1:0]             addrHold_ff, nxt_addrHold;
	logic                       wrEn;
	logic [jfp_pkg::BYTE_W-1:0] wrData;
	logic [AW-1:0]              rdAddr;
	logic [jfp_pkg::BYTE_W-1:0] rdData;
	logic                       unlocked;
	logic                       selFill, selDump, selCmd, selKey, selRst;

	// Chains other than reset and unlock stay dead unless unlocked
	assign unlocked = keyOk_ff & resetHold_ff;                          // RULE14
	assign selRst   = isInstr(instr, jfp_pkg::scan_reset_instr);
	assign selKey   = isInstr(instr, jfp_pkg::program_unlock_instr);
	assign selCmd   = isInstr(instr, jfp_pkg::program_cmd_instr) & unlocked;
	assign selFill  = isInstr(instr, jfp_pkg::page_fill_instr) & unlocked;
	assign selDump  = isInstr(instr, jfp_pkg::page_dump_instr) & unlocked;

	// Next-state for all chains
	always_comb begin
		nxt_resetHold = resetHold_ff;
		nxt_keySr     = keySr_ff;
		nxt_keyOk     = keyOk_ff;
		nxt_cmdSr     = cmdSr_ff;
		nxt_addr      = addr_ff;
		nxt_bitCnt    = bitCnt_ff;
		nxt_byteAddr  = byteAddr_ff;
		nxt_byteSr    = byteSr_ff;
		nxt_fillTgl   = fillTgl_ff;
		nxt_addrHold  = addrHold_ff;
		nxt_tdo       = tdo_ff;
		wrEn          = 1'b0;
		wrData        = {tdi, byteSr_ff[jfp_pkg::BYTE_W-1:1]};
		rdAddr        = byteAddr_ff;
		if (selRst) begin
			if (shiftDr) begin
				nxt_resetHold = tdi;                // RULE8 RULE12
				nxt_tdo       = resetHold_ff;
			end
		end else if (selKey) begin
			if (shiftDr) begin
				nxt_keySr = {tdi, keySr_ff[jfp_pkg::KEY_W-1:1]};
				nxt_tdo   = keySr_ff[0];
			end
			if (updateDr) begin
				// Any other value, all zeros included, leaves the mode
				nxt_keyOk = (keySr_ff == jfp_pkg::UNLOCK_KEY); // RULE9 RULE11
			end
		end else if (selCmd) begin
			if (shiftDr) begin
				nxt_cmdSr = {tdi, cmdSr_ff[jfp_pkg::CMD_W-1:1]};
				nxt_tdo   = cmdSr_ff[0];
			end
			if (updateDr) begin
				// No-op halves load nothing; only address loads act
				case (cmdSr_ff[jfp_pkg::CMD_W-1:jfp_pkg::CMD_OP_LSB]) // RULE13 RULE10
					jfp_pkg::CMD_ADDR_HI: nxt_addr = {cmdSr_ff[7:0], addr_ff[7:0]};
					jfp_pkg::CMD_ADDR_LO: nxt_addr = {addr_ff[AWD-1:8], cmdSr_ff[7:0]};
					default:              nxt_addr = addr_ff;
				endcase
			end
		end else if (selFill) begin
			if (captureDr) begin
				nxt_bitCnt   = '0;                              // RULE15
				nxt_byteAddr = '0;
			end else if (shiftDr) begin
				nxt_byteSr = wrData;                // RULE2
				nxt_bitCnt = bitCnt_ff + 3'h1;
				nxt_tdo    = byteSr_ff[0];
				if (bitCnt_ff == jfp_pkg::BIT_LAST) begin
					wrEn         = 1'b1;                        // RULE1
					nxt_byteAddr = byteAddr_ff + 1'b1;          // RULE15
					if (&byteAddr_ff) begin
						nxt_fillTgl  = ~fillTgl_ff;             // RULE3
						nxt_addrHold = addr_ff;
					end
				end
			end
		end else if (selDump) begin
			if (captureDr) begin
				// Read of byte 0 issued now, lands during the first shifts
				nxt_bitCnt   = '0;
				nxt_byteAddr = '0;                              // RULE15
				rdAddr       = '0;
			end else if (shiftDr) begin
				nxt_bitCnt = bitCnt_ff + 3'h1;
				nxt_byteSr = byteSr_ff >> 1;        // RULE6
				nxt_tdo    = byteSr_ff[0];          // RULE5
				if (bitCnt_ff == jfp_pkg::BIT_LAST) begin
					nxt_byteSr   = rdData;                      // RULE4
					nxt_byteAddr = byteAddr_ff + 1'b1;
					rdAddr       = byteAddr_ff + 1'b1;
				end
			end
		end
	end

	// Scan-side registers
	always_ff @(posedge tck) begin
		if (tapReset) begin
			resetHold_ff <= 1'b0;
			keySr_ff     <= '0;
			keyOk_ff     <= 1'b0;
			cmdSr_ff     <= '0;
			addr_ff      <= jfp_pkg::ADDR_RST;
			bitCnt_ff    <= '0;
			byteAddr_ff  <= '0;
			byteSr_ff    <= '0;
			tdo_ff       <= 1'b0;
			fillTgl_ff   <= 1'b0;
			addrHold_ff  <= jfp_pkg::ADDR_RST;
		end else begin
			resetHold_ff <= nxt_resetHold;
			keySr_ff     <= nxt_keySr;
			keyOk_ff     <= nxt_keyOk;
			cmdSr_ff     <= nxt_cmdSr;
			addr_ff      <= nxt_addr;
			bitCnt_ff    <= nxt_bitCnt;
			byteAddr_ff  <= nxt_byteAddr;
			byteSr_ff    <= nxt_byteSr;
			tdo_ff       <= nxt_tdo;
			fillTgl_ff   <= nxt_fillTgl;
			addrHold_ff  <= nxt_addrHold;
		end
	end
	assign tdo = tdo_ff;

	// Page buffer, written by the fill chain and read by the dump chain
	jfp_page_mem #(
		.WIDTH (jfp_pkg::BYTE_W),
		.DEPTH (jfp_pkg::PAGE_BYTES),
		.AW    (AW)
	) u_mem (
		.clk    (tck),
		.wrEn   (wrEn),
		.wrAddr (byteAddr_ff),
		.wrData (wrData),
		.rdAddr (rdAddr),
		.rdData (rdData)
	);

	////////////////////////////////////////////////////////////////////////
	// Core clock domain: levels by two flops, fill event by toggle
	logic [2:0]     syncA_ff, syncB_ff, nxt_syncA, nxt_syncB;
	logic           tglSeen_ff, nxt_tglSeen;
	logic           holdReset_ff, progMode_ff, pageFilled_ff;
	logic           nxt_holdReset, nxt_progMode, nxt_pageFilled;
	logic [AWD-1:0] flashAddr_ff, eeAddr_ff, nxt_flashAddr, nxt_eeAddr;
	logic [AWD-1:0] flashMask, eeMask;

	// Masks drop unimplemented address bits; the flash mask also drops the in-page word bits
	assign flashMask = AWD'((32'h1 << (jfp_pkg::flash_addr_top_bit + 1)) - 1)
		& ~AWD'((32'h1 << jfp_pkg::PAGE_WORD_BITS) - 1);
	assign eeMask = AWD'((32'h1 << (jfp_pkg::eeprom_addr_top_bit + 1)) - 1);

	// Next values on the core side
	always_comb begin
		nxt_syncA      = {fillTgl_ff, unlocked, resetHold_ff};
		nxt_syncB      = syncA_ff;
		nxt_tglSeen    = syncB_ff[2];
		nxt_holdReset  = syncB_ff[0];
		nxt_progMode   = syncB_ff[1];
		nxt_pageFilled = syncB_ff[2] ^ tglSeen_ff;
		nxt_flashAddr  = flashAddr_ff;
		nxt_eeAddr     = eeAddr_ff;
		// Held word is stable long before its toggle arrives here
		if (syncB_ff[2] ^ tglSeen_ff) begin
			nxt_flashAddr = addrHold_ff & flashMask;    // RULE7
			nxt_eeAddr    = addrHold_ff & eeMask;       // RULE7
		end
	end

	// Core-side registers
	always_ff @(posedge clk) begin
		if (reset) begin
			syncA_ff      <= '0;
			syncB_ff      <= '0;
			tglSeen_ff    <= 1'b0;
			holdReset_ff  <= 1'b0;
			progMode_ff   <= 1'b0;
			pageFilled_ff <= 1'b0;
			flashAddr_ff  <= jfp_pkg::ADDR_RST;
			eeAddr_ff     <= jfp_pkg::ADDR_RST;
		end else begin
			syncA_ff      <= nxt_syncA;
			syncB_ff      <= nxt_syncB;
			tglSeen_ff    <= nxt_tglSeen;
			holdReset_ff  <= nxt_holdReset;
			progMode_ff   <= nxt_progMode;
			pageFilled_ff <= nxt_pageFilled;
			flashAddr_ff  <= nxt_flashAddr;
			eeAddr_ff     <= nxt_eeAddr;
		end
	end
	assign holdReset     = holdReset_ff;
	assign progMode      = progMode_ff;
	assign pageFilled    = pageFilled_ff;
	assign flashWordAddr = flashAddr_ff;
	assign eepromAddr    = eeAddr_ff;
endmodule // jfp_prog_port
`default_nettype wire

/* verif/jfp_prog_properties.sv */
// Purpose: Port assertions for the page programming block
// Assumes: Bound onto every instance of the programming port
// Notes:   Two clock domains, so each property names its own clock
`timescale 1ns/1ps
`default_nettype none
module jfp_prog_properties (
	input wire logic                      clk,           // Core clock
	input wire logic                      reset,         // Core reset
	input wire logic                      tck,           // Scan clock
	input wire logic                      tapReset,      // Scan reset
	input wire logic                      shiftDr,       // Shift state
	input wire logic                      tdo,           // Scan data out
	input wire logic                      holdReset,     // Core held
	input wire logic                      progMode,      // Mode active
	input wire logic                      pageFilled,    // Fill done
	input wire logic [jfp_pkg::ADDR_W-1:0] flashWordAddr, // Page base
	input wire logic [jfp_pkg::ADDR_W-1:0] eepromAddr     // Eeprom address
);
	// Mode may only exist while the core is held
	mode_needs_hold_a: assert property (@(posedge clk) disable iff (reset)
		progMode |-> holdReset) else $error("mode without held reset");
	entry_after_hold_a: assert property (@(posedge clk) disable iff (reset)
		$rose(progMode) |-> $past(holdReset)) else $error("mode before hold");
	hold_drop_mode_a: assert property (@(posedge clk) disable iff (reset)
		$fell(holdReset) |-> ##[0:3] !progMode) else $error("mode outlives hold");
	fill_one_pulse_a: assert property (@(posedge clk) disable iff (reset)
		pageFilled |=> !pageFilled) else $error("fill pulse too long");
	fill_in_mode_a: assert property (@(posedge clk) disable iff (reset)
		pageFilled |-> progMode) else $error("fill outside mode");
	page_base_a: assert property (@(posedge clk) disable iff (reset)
		flashWordAddr[6:0] == 7'h00) else $error("page base not aligned");
	eeprom_top_a: assert property (@(posedge clk) disable iff (reset)
		eepromAddr[15:12] == 4'h0) else $error("eeprom high bits kept");
	// Output moves only on shift edges, so idle chains cannot leak data
	tdo_frozen_a: assert property (@(posedge tck) disable iff (tapReset)
		!shiftDr |=> $stable(tdo)) else $error("tdo moved without shift");
endmodule // jfp_prog_properties
bind jfp_prog_port jfp_prog_properties u_props (.clk, .reset, .tck, .tapReset,
	.shiftDr, .tdo, .holdReset, .progMode, .pageFilled, .flashWordAddr,
	.eepromAddr);
`default_nettype wire

/* verif/jfp_programmer_model.sv */
// Purpose: Scan-port programmer driving capture, shift and update
// Assumes: Scan clock runs free at 12 ns
// Notes:   Keeps every bit seen on tdo of the last scan in got
`timescale 1ns/1ps
`default_nettype none
module jfp_programmer_model (
	output logic       tck,       // Scan clock
	output logic       tapReset,  // Scan reset
	output logic [3:0] instr,     // Selected instruction
	output logic       captureDr, // Capture state
	output logic       shiftDr,   // Shift state
	output logic       updateDr,  // Update state
	output logic       tdi,       // Scan data in
	input  wire logic  tdo        // Scan data out
);
	logic got [0:2063]; // Bit seen after each shift edge
	// Idle levels, scan reset released after a few edges
	initial begin
		tck = 1'b0;
		tapReset = 1'b1;
		instr = 4'h0;
		captureDr = 1'b0;
		shiftDr = 1'b0;
		updateDr = 1'b0;
		tdi = 1'b0;
		repeat (4) @(posedge tck);
		#1 tapReset = 1'b0;
	end
	always #6 tck = ~tck;
	// Page fill pattern, distinct in every byte
	function automatic logic [7:0] pat(input int i);
		return i[7:0] ^ 8'h5a;
	endfunction
	// One capture, n shifts LSB first, one update
	task automatic scan(input logic [3:0] ir, input logic [15:0] val,
			input int n, input bit page);
		logic [7:0] b;
		@(posedge tck);
		#1 instr = ir;
		captureDr = 1'b1;
		@(posedge tck);
		#1 captureDr = 1'b0;
		shiftDr = 1'b1;
		for (int k = 0; k < n; k++) begin
			b = pat(k / 8);
			tdi = page ? b[k % 8] : val[k % 16];
			@(posedge tck);
			#1 got[k] = tdo;
		end
		shiftDr = 1'b0;
		updateDr = 1'b1;
		@(posedge tck);
		#1 updateDr = 1'b0;
	endtask
endmodule // jfp_programmer_model
`default_nettype wire

/* verif/tb.sv */
// Purpose: Self-checking bench for entry, page fill, dump and exit
// Assumes: Programmer model drives the scan side
// Notes:   Core outputs are read after a settle of ten core clocks
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        clk, reset, tdo, holdReset, progMode, pageFilled;
	logic [15:0] flashWordAddr, eepromAddr;
	wire logic   tck, tapReset, captureDr, shiftDr, updateDr, tdi;
	wire logic [3:0] instr;
	int          miscompares = 0, checked = 0, fills = 0;
	jfp_prog_port u_dut (.clk, .reset, .tck, .tapReset, .instr, .captureDr,
		.shiftDr, .updateDr, .tdi, .tdo, .holdReset, .progMode, .pageFilled,
		.flashWordAddr, .eepromAddr);
	jfp_programmer_model u_prog (.tck, .tapReset, .instr, .captureDr,
		.shiftDr, .updateDr, .tdi, .tdo);
	always #2.5 clk = ~clk;
	// Count fill pulses so a doubled pulse shows up too
	always @(posedge clk) if (pageFilled === 1'b1) fills <= fills + 1;
	task automatic check(input string what, input logic [15:0] seen,
			input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Core side lags the scan side by a few clocks
	task automatic settle();
		repeat (10) @(posedge clk);
		#1;
	endtask
	task automatic entry();
		u_prog.scan(jfp_pkg::program_unlock_instr, jfp_pkg::UNLOCK_KEY, 16, 0);
		settle();
		check("mode no hold", 16'(progMode), 16'h0);
		// Clear the stale key so the hold is in place before any key lands
		u_prog.scan(jfp_pkg::program_unlock_instr, 16'h0000, 16, 0);
		u_prog.scan(jfp_pkg::scan_reset_instr, 16'h0001, 1, 0);
		u_prog.scan(jfp_pkg::program_unlock_instr, 16'ha371, 16, 0);
		settle();
		check("hold set", 16'(holdReset), 16'h1);
		check("mode bad key", 16'(progMode), 16'h0);
		u_prog.scan(jfp_pkg::program_unlock_instr, 16'ha370, 16, 0);
		settle();
		check("mode key", 16'(progMode), 16'h1);
	endtask
	task automatic fillPage();
		int f0;
		u_prog.scan(jfp_pkg::program_cmd_instr, 16'h07ff, 15, 0);
		u_prog.scan(jfp_pkg::program_cmd_instr, 16'h03ff, 15, 0);
		f0 = fills;
		u_prog.scan(jfp_pkg::page_fill_instr, 16'h0000, 2048, 1);
		settle();
		check("fill pulses", 16'(fills - f0), 16'h1);
		check("flash base", flashWordAddr, 16'hff80);
		check("eeprom addr", eepromAddr, 16'h0fff);
	endtask
	task automatic dumpPage();
		logic [7:0] v;
		u_prog.scan(jfp_pkg::page_dump_instr, 16'h0000, 2056, 0);
		for (int n = 0; n < 256; n++) begin
			for (int b = 0; b < 8; b++) v[b] = u_prog.got[8 + n * 8 + b];
			check("dump byte", 16'(v), 16'(u_prog.pat(n)));
		end
	endtask
	task automatic leaveMode();
		int f0;
		u_prog.scan(jfp_pkg::program_cmd_instr, 16'h2300, 15, 0);
		u_prog.scan(jfp_pkg::program_cmd_instr, 16'h3300, 15, 0);
		u_prog.scan(jfp_pkg::program_unlock_instr, 16'h0000, 16, 0);
		settle();
		check("mode off", 16'(progMode), 16'h0);
		check("hold kept", 16'(holdReset), 16'h1);
		u_prog.scan(jfp_pkg::scan_reset_instr, 16'h0000, 1, 0);
		settle();
		check("hold off", 16'(holdReset), 16'h0);
		f0 = fills;
		u_prog.scan(jfp_pkg::page_fill_instr, 16'h0000, 2048, 1);
		settle();
		check("fill refused", 16'(fills - f0), 16'h0);
	endtask
	initial begin
		clk = 1'b0;
		reset = 1'b1;
		repeat (16) @(posedge clk);
		#1 reset = 1'b0;
		entry();
		fillPage();
		dumpPage();
		leaveMode();
		conclude();
	end
	// Hang guard, several times the normal run length
	initial begin
		repeat (90000) @(posedge clk);
		miscompares++;
		conclude();
	end
endmodule // tb
`default_nettype wire
